// ---- rtl/lsc_pkg.sv ----
/*
 Package for the partial execute unit: opcode selects, widths, flag fields and state types.
 Assumes a decoder upstream that presents one instruction per enabled cycle.
*/
package lsc_pkg;
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 7;
  localparam int PC_W      = 13;
  localparam int TGT_W     = 11;
  localparam int BIT_W     = 3;
  localparam int LATCH_LO  = 3;
  localparam int LATCH_HI  = 4;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [PC_W-1:0]   PC_ONE    = 13'h0001;
  localparam logic [PC_W-1:0]   PC_RESET  = 13'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;

  typedef enum logic [2:0] {
    OP_NOP,
    OP_AND_IMM_ACC,
    OP_AND_REG_WITH_ACC,
    OP_INVERT_REG,
    OP_SKIP_IF_BIT_LOW,
    OP_SKIP_IF_BIT_HIGH,
    OP_KICK_DOG,
    OP_CALL
  } lsc_op_e;

  typedef enum {
    ST_RUN,
    ST_BUBBLE
  } lsc_state_e;

  typedef struct packed {
    lsc_op_e               op;
    logic [DATA_W-1:0]     imm;
    logic [ADDR_W-1:0]     addr;
    logic                  dest;
    logic [BIT_W-1:0]      bit_sel;
    logic [TGT_W-1:0]      target;
  } lsc_instr_s;

  typedef struct packed {
    logic                  we;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     data;
  } lsc_wr_s;

  typedef struct packed {
    lsc_state_e            state;
    logic [DATA_W-1:0]     acc;
    logic                  zero_flag;
    logic [PC_W-1:0]       pc;
    lsc_wr_s               wr;
    logic                  push;
    logic [PC_W-1:0]       stack_head;
    logic                  dog_clear;
    logic                  dog_expiry_flag_n;
    logic                  sleep_flag_n;
    logic                  take;
  } lsc_state_s;
endpackage

// ---- rtl/lsc_exec.sv ----
/*
 Execute unit for AND, invert, bit-test-skip, watchdog kick and call.
 Assumes the file register read data for instr.addr is valid in the same cycle, and that
 instr is held steady by the fetch logic while instr_valid is high and take is low.
*/
// What this block does
// - AND accumulator with 8-bit immediate into accumulator, only zero flag changes.
// - AND accumulator with addressed file register, only zero flag changes.
// - Destination bit 0 writes accumulator, 1 writes file register back.
// - Invert addressed file register, route by destination, only zero flag changes.
// - Skip-if-bit-low runs next instruction when the selected bit is one.
// - Skip-if-bit-low with bit zero discards next, runs a no-op, two cycles.
// - Skip-if-bit-high with bit one discards next, runs a no-op, two cycles.
// - Bit tests and call leave all status flags unchanged.
// - Watchdog kick clears watchdog counter and its prescaler.
// - Watchdog kick sets expiry and sleep status flags, both active low, to one.
// - Call pushes program counter plus one onto the return stack.
// - Call loads 11-bit target into program counter bits 10 to 0.
// - Call fills program counter bits 12 to 11 from latch bits 4 to 3.
// - Call takes two instruction cycles.
// - Program counter change or true skip costs a second no-op cycle.
module lsc_exec
  import lsc_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              clk_en,
  input  wire logic              instr_valid,
  input  wire lsc_instr_s        instr,
  input  wire logic [DATA_W-1:0] reg_rdata,
  input  wire logic [DATA_W-1:0] upper_pc_latch,
  output logic [DATA_W-1:0]      acc,
  output logic                   zero_flag,
  output logic [PC_W-1:0]        pc,
  output lsc_wr_s                reg_wr,
  output logic                   push,
  output logic [PC_W-1:0]        stack_head,
  output logic                   dog_clear,
  output logic                   dog_expiry_flag_n,
  output logic                   sleep_flag_n,
  output logic                   take
);
  lsc_state_s s_reg;
  lsc_state_s s_next;
  logic [DATA_W-1:0] res;
  logic              bit_val;

  always_comb begin
    s_next         = s_reg;
    res            = ZERO_BYTE;
    bit_val        = reg_rdata[instr.bit_sel];
    s_next.wr.we   = 1'b0;
    s_next.push    = 1'b0;
    s_next.dog_clear = 1'b0;
    s_next.take    = 1'b0;
    case (s_reg.state)
      ST_BUBBLE: begin
        // Second cycle: instruction slot consumed as a no-op
        s_next.state = ST_RUN;
        s_next.take  = instr_valid;
      end
      ST_RUN: begin
        if (instr_valid) begin
          s_next.take = 1'b1;
          s_next.pc   = s_reg.pc + PC_ONE;
          case (instr.op)
            OP_AND_IMM_ACC: begin
              res          = s_reg.acc & instr.imm;
              s_next.acc   = res;
              s_next.zero_flag = (res == ZERO_BYTE);
            end
            OP_AND_REG_WITH_ACC, OP_INVERT_REG: begin
              if (instr.op == OP_INVERT_REG) begin
                res = ~reg_rdata;
              end else begin
                res = s_reg.acc & reg_rdata;
              end
              s_next.zero_flag = (res == ZERO_BYTE);
              if (instr.dest) begin
                s_next.wr.we   = 1'b1;
                s_next.wr.addr = instr.addr;
                s_next.wr.data = res;
              end else begin
                s_next.acc = res;
              end
            end
            OP_SKIP_IF_BIT_LOW: begin
              // Flags untouched
              if (!bit_val) begin
                s_next.state = ST_BUBBLE;
              end
            end
            OP_SKIP_IF_BIT_HIGH: begin
              if (bit_val) begin
                s_next.state = ST_BUBBLE;
              end
            end
            OP_KICK_DOG: begin
              s_next.dog_clear         = 1'b1;
              s_next.dog_expiry_flag_n = 1'b1;
              s_next.sleep_flag_n      = 1'b1;
            end
            OP_CALL: begin
              s_next.push       = 1'b1;
              s_next.stack_head = s_reg.pc + PC_ONE;
              s_next.pc = {upper_pc_latch[LATCH_HI:LATCH_LO], instr.target};
              s_next.state = ST_BUBBLE;
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        s_next.state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_reg <= '{state: ST_RUN, acc: ACC_RESET, zero_flag: 1'b0, pc: PC_RESET,
                 wr: '0, push: 1'b0, stack_head: PC_RESET, dog_clear: 1'b0,
                 dog_expiry_flag_n: 1'b1, sleep_flag_n: 1'b1, take: 1'b0};
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign acc               = s_reg.acc;
  assign zero_flag         = s_reg.zero_flag;
  assign pc                = s_reg.pc;
  assign reg_wr            = s_reg.wr;
  assign push              = s_reg.push;
  assign stack_head        = s_reg.stack_head;
  assign dog_clear         = s_reg.dog_clear;
  assign dog_expiry_flag_n = s_reg.dog_expiry_flag_n;
  assign sleep_flag_n      = s_reg.sleep_flag_n;
  assign take              = s_reg.take;

  and_imm_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_AND_IMM_ACC
      |=> acc == ($past(acc) & $past(instr.imm)))
    else $error("and immediate result wrong");

  and_reg_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_AND_REG_WITH_ACC && instr.dest
      |=> reg_wr.we && reg_wr.data == ($past(acc) & $past(reg_rdata)) && $stable(acc))
    else $error("and register to file wrong");

  dest_acc_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_INVERT_REG && !instr.dest
      |=> !reg_wr.we && acc == ~$past(reg_rdata))
    else $error("invert to accumulator wrong");

  zero_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_INVERT_REG
      |=> zero_flag == ($past(reg_rdata) == ~ZERO_BYTE))
    else $error("zero flag wrong after invert");

  skip_low_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_SKIP_IF_BIT_LOW && !bit_val
      |=> s_reg.state == ST_BUBBLE)
    else $error("skip on clear bit missing");

  noskip_low_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_SKIP_IF_BIT_LOW && bit_val
      |=> s_reg.state == ST_RUN)
    else $error("spurious skip on set bit");

  skip_high_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_SKIP_IF_BIT_HIGH
      |=> s_reg.state == ($past(bit_val) ? ST_BUBBLE : ST_RUN))
    else $error("skip on set bit wrong");

  flags_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && (instr.op == OP_CALL || instr.op == OP_SKIP_IF_BIT_HIGH)
      |=> $stable(zero_flag) && $stable(dog_expiry_flag_n) && $stable(sleep_flag_n))
    else $error("flags changed by test or call");

  dog_kick_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_KICK_DOG
      |=> dog_clear && dog_expiry_flag_n && sleep_flag_n)
    else $error("watchdog kick incomplete");

  call_pc_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_CALL
      |=> push && stack_head == $past(pc) + PC_ONE
          && pc == {$past(upper_pc_latch[LATCH_HI:LATCH_LO]), $past(instr.target)})
    else $error("call target or push wrong");

  call_two_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_CALL
      |=> s_reg.state == ST_BUBBLE ##1 (!$past(clk_en) || s_reg.state == ST_RUN))
    else $error("call not two cycles");

  imm_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_AND_IMM_ACC
      |=> zero_flag == (($past(acc) & $past(instr.imm)) == ZERO_BYTE))
    else $error("zero flag wrong after and immediate");

  imm_no_side_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_AND_IMM_ACC
      |=> !reg_wr.we && !push && !dog_clear)
    else $error("and immediate touched more than accumulator");

  reg_to_acc_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_AND_REG_WITH_ACC && !instr.dest
      |=> !reg_wr.we && acc == ($past(acc) & $past(reg_rdata)))
    else $error("and register to accumulator wrong");

  reg_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_AND_REG_WITH_ACC
      |=> zero_flag == (($past(acc) & $past(reg_rdata)) == ZERO_BYTE))
    else $error("zero flag wrong after and register");

  inv_to_file_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_INVERT_REG && instr.dest
      |=> reg_wr.we && reg_wr.data == ~$past(reg_rdata) && $stable(acc))
    else $error("invert to file wrong");

  write_addr_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.dest
      && (instr.op == OP_AND_REG_WITH_ACC || instr.op == OP_INVERT_REG)
      |=> reg_wr.addr == $past(instr.addr))
    else $error("file write address wrong");

  write_only_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && !(s_reg.state == ST_RUN && instr_valid && instr.dest
      && (instr.op == OP_AND_REG_WITH_ACC || instr.op == OP_INVERT_REG))
      |=> !reg_wr.we)
    else $error("spurious file write");

  skip_flags_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_SKIP_IF_BIT_LOW
      |=> $stable(zero_flag) && $stable(acc) && !reg_wr.we)
    else $error("flags changed by skip on clear");

  skip_high_keep_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_SKIP_IF_BIT_HIGH
      |=> $stable(acc) && !reg_wr.we && !push)
    else $error("state changed by skip on set");

  noskip_high_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_SKIP_IF_BIT_HIGH && !bit_val
      |=> s_reg.state == ST_RUN)
    else $error("spurious skip on clear bit");

  next_runs_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_SKIP_IF_BIT_LOW && bit_val
      |=> s_reg.state == ST_RUN && take)
    else $error("next instruction not run after clear test");

  kick_flags_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_KICK_DOG
      |=> dog_expiry_flag_n && sleep_flag_n && $stable(zero_flag))
    else $error("status flags not set by kick");

  kick_only_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && !(s_reg.state == ST_RUN && instr_valid && instr.op == OP_KICK_DOG)
      |=> !dog_clear)
    else $error("spurious watchdog clear");

  push_only_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && !(s_reg.state == ST_RUN && instr_valid && instr.op == OP_CALL)
      |=> !push)
    else $error("spurious stack push");

  stack_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && !(s_reg.state == ST_RUN && instr_valid && instr.op == OP_CALL)
      |=> $stable(stack_head))
    else $error("stack head changed without call");

  call_low_pc_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_CALL
      |=> pc[TGT_W-1:0] == $past(instr.target))
    else $error("call low target bits wrong");

  call_high_pc_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_CALL
      |=> pc[PC_W-1:TGT_W] == $past(upper_pc_latch[LATCH_HI:LATCH_LO]))
    else $error("call high bits not from latch");

  call_flags_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op == OP_CALL
      |=> $stable(acc) && $stable(zero_flag) && !reg_wr.we)
    else $error("call changed data state");

  run_pc_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && instr_valid && instr.op != OP_CALL
      |=> pc == $past(pc) + PC_ONE)
    else $error("program counter not advanced");

  idle_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_RUN && !instr_valid
      |=> $stable(pc) && !take)
    else $error("idle cycle changed program counter");

  bubble_pc_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_BUBBLE
      |=> $stable(pc) && s_reg.state == ST_RUN)
    else $error("no-op cycle moved program counter");

  bubble_noop_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_BUBBLE
      |=> $stable(acc) && $stable(zero_flag) && !reg_wr.we && !push && !dog_clear)
    else $error("no-op cycle had an effect");

  bubble_take_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && s_reg.state == ST_BUBBLE
      |=> take == $past(instr_valid))
    else $error("discarded slot not consumed");
endmodule

// ---- tb/lsc_tb.sv ----
/*
 Self-checking bench for the partial execute unit, with a cycle model of the same unit.
 Assumes the package and the execute unit are compiled first, and needs no other files.
*/
module testbench
  import lsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              sys_clk = 1'b0;
  logic              srst = 1'b1;
  logic              clk_en = 1'b1;
  logic              instr_valid = 1'b0;
  lsc_instr_s        instr = '0;
  logic [DATA_W-1:0] reg_rdata = 8'h00;
  logic [DATA_W-1:0] upper_pc_latch = 8'h00;
  logic [DATA_W-1:0] acc;
  logic              zero_flag;
  logic [PC_W-1:0]   pc;
  lsc_wr_s           reg_wr;
  logic              push;
  logic [PC_W-1:0]   stack_head;
  logic              dog_clear;
  logic              dog_expiry_flag_n;
  logic              sleep_flag_n;
  logic              take;
  int                err_total = 0;
  int                tests_run = 0;
  logic [DATA_W-1:0] m_acc, m_wdata;
  logic [PC_W-1:0]   m_pc, m_sh;
  logic [ADDR_W-1:0] m_waddr;
  logic              m_z, m_bub, m_we, m_push, m_dc, m_take, m_fl;

  always #2 sys_clk = ~sys_clk;

  lsc_exec dut (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .instr_valid(instr_valid), .instr(instr),
    .reg_rdata(reg_rdata), .upper_pc_latch(upper_pc_latch), .acc(acc), .zero_flag(zero_flag), .pc(pc),
    .reg_wr(reg_wr), .push(push), .stack_head(stack_head), .dog_clear(dog_clear),
    .dog_expiry_flag_n(dog_expiry_flag_n), .sleep_flag_n(sleep_flag_n), .take(take));

  task automatic chk(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s differs from model", $time, what);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One clock: model update at the edge, compare after it, then drive the next inputs
  task automatic cyc(input bit en_rand);
    logic [DATA_W-1:0] r;
    @(posedge sys_clk);
    if (srst) begin
      {m_acc, m_z, m_pc, m_bub, m_sh, m_we, m_push, m_dc, m_take} = '0;
      m_fl = 1'b1;
    end else if (clk_en) begin
      {m_we, m_push, m_dc} = '0;
      m_take = instr_valid;
      if (m_bub) m_bub = 1'b0;
      else if (instr_valid) begin
        m_pc = m_pc + PC_ONE;
        case (instr.op)
          OP_AND_IMM_ACC: begin
            m_acc = m_acc & instr.imm;
            m_z = (m_acc == ZERO_BYTE);
          end
          OP_AND_REG_WITH_ACC, OP_INVERT_REG: begin
            r = (instr.op == OP_INVERT_REG) ? ~reg_rdata : (m_acc & reg_rdata);
            m_z = (r == ZERO_BYTE);
            if (instr.dest) {m_we, m_waddr, m_wdata} = {1'b1, instr.addr, r};
            else m_acc = r;
          end
          OP_SKIP_IF_BIT_LOW: m_bub = !reg_rdata[instr.bit_sel];
          OP_SKIP_IF_BIT_HIGH: m_bub = reg_rdata[instr.bit_sel];
          OP_KICK_DOG: {m_dc, m_fl} = 2'b11;
          OP_CALL: begin
            {m_push, m_sh, m_bub} = {1'b1, m_pc, 1'b1};
            m_pc = {upper_pc_latch[LATCH_HI:LATCH_LO], instr.target};
          end
          default: ;
        endcase
      end
    end
    #1;
    chk(acc === m_acc, "acc");
    chk(zero_flag === m_z, "zero flag");
    chk(pc === m_pc, "pc");
    chk(reg_wr.we === m_we, "write strobe");
    if (m_we) chk(reg_wr.addr === m_waddr && reg_wr.data === m_wdata, "write");
    chk(push === m_push && stack_head === m_sh, "push");
    chk(dog_clear === m_dc, "dog clear");
    chk(dog_expiry_flag_n === m_fl && sleep_flag_n === m_fl, "status");
    chk(take === m_take, "take");
    if (srst || clk_en || !instr_valid) begin
      instr = lsc_instr_s'(33'({$urandom(), $urandom()}));
      reg_rdata = ($urandom_range(0, 3) == 0) ? 8'hff : 8'($urandom());
      upper_pc_latch = 8'($urandom());
      instr_valid = ($urandom_range(0, 7) != 0);
    end
    clk_en = en_rand ? ($urandom_range(0, 3) != 0) : 1'b1;
  endtask

  initial begin
    void'($urandom(2952));
    repeat (3) cyc(1'b0);
    srst = 1'b0;
    repeat (600) cyc(1'b0);
    $display("Test back to back done");
    repeat (600) cyc(1'b1);
    $display("Test clock enable gaps done");
    repeat (20) cyc(1'b1);
    srst = 1'b1;
    cyc(1'b1);
    srst = 1'b0;
    repeat (200) cyc(1'b1);
    $display("Test mid-run reset done");
    print_verdict();
  end
endmodule
